// >>> include/flash_host_pkg.sv
// package: constants, register map and types of the parallel flash host controller
// assumes a 40 MHz clock and an 8-bit asynchronous flash with 18 address lines
package flash_host_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam int SECT_W = 10;
	localparam int LONG_W = 20;

	typedef logic [LONG_W-1:0] long_t;
	typedef logic [3:0]        short_t;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PS      = 25000;
	localparam int TWP_NS      = 90;
	localparam int TWPH_NS     = 100;
	localparam int TACC_NS     = 150;
	localparam int TOEHP_NS    = 150;
	localparam int BYTE_LOAD_WINDOW_US     = 150;
	localparam int TWC_MS      = 10;
	localparam short_t WP_CYC   = short_t'((TWP_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam short_t WPH_CYC  = short_t'((TWPH_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam short_t ACC_CYC  = short_t'((TACC_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam short_t OEHP_CYC = short_t'((TOEHP_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam int BLC_CYC_DEF  = (BYTE_LOAD_WINDOW_US * 1000000) / CLK_PS;
	localparam int TWC_CYC_DEF  = (TWC_MS * 1000) * (1000000 / CLK_PS);

	// ----------------------------------------------------------------
	// register map (byte offsets) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_RDATA  = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ISTAT  = 8'h14;
	localparam logic [7:0] OFS_IMASK  = 8'h18;
	localparam int ST_BUSY    = 0;
	localparam int ST_LOADING = 1;
	localparam int ST_COUNT   = 4;
	localparam int EV_DONE = 0;
	localparam int EV_PROG = 1;
	localparam int EV_ERR  = 2;
	localparam int EV_WIN  = 3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_LOAD = 2'h1,
		OP_CMD  = 2'h2,
		OP_POLL = 2'h3
	} op_t;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_SETUP = 3'h1,
		S_WLOW  = 3'h2,
		S_WHIGH = 3'h3,
		S_RLOW  = 3'h4,
		S_RHIGH = 3'h5
	} state_t;

	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        dq_o;
		logic              dq_oe;
	} flash_pins_t;

	localparam flash_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
		addr: '0, dq_o: 8'h00, dq_oe: 1'b0};

endpackage

// >>> rtl/flash_host.sv
// module: host controller that drives a sector-programmed parallel flash by its strobes
// assumes an AXI4-Lite master on the register side and the flash pins on the other
//
// How it works
// - during each sector load byte, the upper address carries that sector's address
// - each next byte load starts within the byte load window, else programming begins
// - after protection enable, a full sector is loaded; loaded-byte count is reported
// - only a change of toggle bit between two reads means still busy
// - toggle polling keeps the same address on every read
// - command cycles use only the low fifteen address bits and byte data
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module flash_host
	import flash_host_pkg::*;
#(
	parameter int unsigned BLC_CYCLES = BLC_CYC_DEF,
	parameter int unsigned TWC_CYCLES = TWC_CYC_DEF
) (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic [7:0]        S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [7:0]        S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	output logic                   IRQ,
	output logic                   CE_N,
	output logic                   OE_N,
	output logic                   WE_N,
	output logic [ADDR_W-1:0]      ADDR,
	output logic [7:0]             DQ_O,
	output logic                   DQ_OE,
	input  wire logic [7:0]        DQ_I
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_t            state, next_state;
	op_t               op, next_op;
	short_t            cnt, next_cnt;
	flash_pins_t       pins, next_pins;
	logic [7:0]        rdata, next_rdata;
	logic              have_prev, next_have_prev;
	logic              prev_t6, next_prev_t6;
	logic              loading, next_loading;
	long_t             win_cnt, next_win_cnt;
	long_t             poll_cnt, next_poll_cnt;
	logic [SECT_W-1:0] sector, next_sector;
	logic [8:0]        load_count, next_load_count;
	logic [3:0]        ev, next_ev;

	logic              aw_held, next_aw_held;
	logic [7:0]        aw_addr, next_aw_addr;
	logic              w_held, next_w_held;
	logic [31:0]       w_data, next_w_data;
	logic              awready, next_awready;
	logic              wready, next_wready;
	logic              arready, next_arready;
	logic              bvalid, next_bvalid;
	logic [1:0]        bresp, next_bresp;
	logic              rvalid, next_rvalid;
	logic [31:0]       rdout, next_rdout;
	logic [1:0]        rresp, next_rresp;
	logic [ADDR_W-1:0] reg_addr, next_reg_addr;
	logic [7:0]        reg_wdata, next_reg_wdata;
	logic [3:0]        istat, next_istat;
	logic [3:0]        imask, next_imask;
	logic              irq, next_irq;
	logic              start;
	op_t               start_op;

	// ----------------------------------------------------------------
	// register read decode
	// ----------------------------------------------------------------
	function automatic logic [32:0] reg_read(input logic [7:0] a);
		logic [31:0] d;
		logic        hit;
		d   = 32'h0000_0000;
		hit = 1'b1;
		if (a == OFS_CMD) begin
			d[1:0] = op;
		end else if (a == OFS_ADDR) begin
			d[ADDR_W-1:0] = reg_addr;
		end else if (a == OFS_WDATA) begin
			d[7:0] = reg_wdata;
		end else if (a == OFS_RDATA) begin
			d[7:0] = rdata;
		end else if (a == OFS_STATUS) begin
			d[ST_BUSY]              = (state != S_IDLE);
			d[ST_LOADING]           = loading;
			d[ST_COUNT+8:ST_COUNT]  = load_count;
		end else if (a == OFS_ISTAT) begin
			d[3:0] = istat;
		end else if (a == OFS_IMASK) begin
			d[3:0] = imask;
		end else begin
			hit = 1'b0;
		end
		return {hit, d};
	endfunction

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	always_comb begin
		logic [32:0] rr;
		logic [32:0] wr;
		rr              = 33'h0_0000_0000;
		wr              = reg_read(aw_addr);
		next_aw_held    = aw_held;
		next_aw_addr    = aw_addr;
		next_w_held     = w_held;
		next_w_data     = w_data;
		next_bvalid     = bvalid && !S_AXI_BREADY;
		next_bresp      = bresp;
		next_rvalid     = rvalid && !S_AXI_RREADY;
		next_rdout      = rdout;
		next_rresp      = rresp;
		next_reg_addr   = reg_addr;
		next_reg_wdata  = reg_wdata;
		next_imask      = imask;
		next_istat      = istat;
		start           = 1'b0;
		start_op        = OP_READ;
		if (S_AXI_AWVALID && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wready) begin
			next_w_held = 1'b1;
			next_w_data = S_AXI_WDATA;
		end
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if (aw_addr == OFS_CMD) begin
				start    = (state == S_IDLE);
				start_op = op_t'(w_data[1:0]);
			end else if (aw_addr == OFS_ADDR) begin
				next_reg_addr = w_data[ADDR_W-1:0];
			end else if (aw_addr == OFS_WDATA) begin
				next_reg_wdata = w_data[7:0];
			end else if (aw_addr == OFS_ISTAT) begin
				next_istat = istat & ~w_data[3:0];
			end else if (aw_addr == OFS_IMASK) begin
				next_imask = w_data[3:0];
			end else if (!wr[32]) begin
				next_bresp = RESP_SLVERR;
			end
		end
		// set wins over a same-cycle clear
		next_istat = next_istat | ev;
		if (S_AXI_ARVALID && arready) begin
			rr          = reg_read(S_AXI_ARADDR);
			next_rvalid = 1'b1;
			next_rdout  = rr[31:0];
			next_rresp  = rr[32] ? RESP_OKAY : RESP_SLVERR;
		end
		next_awready = !next_aw_held;
		next_wready  = !next_w_held;
		next_arready = !next_rvalid;
		next_irq     = |(next_istat & next_imask);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_held   <= 1'b0;
			aw_addr   <= 8'h00;
			w_held    <= 1'b0;
			w_data    <= 32'h0000_0000;
			awready   <= 1'b0;
			wready    <= 1'b0;
			arready   <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
			rvalid    <= 1'b0;
			rdout     <= 32'h0000_0000;
			rresp     <= RESP_OKAY;
			reg_addr  <= '0;
			reg_wdata <= 8'h00;
			istat     <= 4'h0;
			imask     <= 4'h0;
			irq       <= 1'b0;
		end else begin
			aw_held   <= next_aw_held;
			aw_addr   <= next_aw_addr;
			w_held    <= next_w_held;
			w_data    <= next_w_data;
			awready   <= next_awready;
			wready    <= next_wready;
			arready   <= next_arready;
			bvalid    <= next_bvalid;
			bresp     <= next_bresp;
			rvalid    <= next_rvalid;
			rdout     <= next_rdout;
			rresp     <= next_rresp;
			reg_addr  <= next_reg_addr;
			reg_wdata <= next_reg_wdata;
			istat     <= next_istat;
			imask     <= next_imask;
			irq       <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// flash strobe sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state      = state;
		next_op         = op;
		next_cnt        = (cnt == 4'h0) ? 4'h0 : short_t'(cnt - 4'h1);
		next_pins       = pins;
		next_rdata      = rdata;
		next_have_prev  = have_prev;
		next_prev_t6    = prev_t6;
		next_loading    = loading;
		next_win_cnt    = win_cnt;
		next_poll_cnt   = poll_cnt;
		next_sector     = sector;
		next_load_count = load_count;
		next_ev         = 4'h0;
		if (loading) begin
			if (win_cnt == '0) begin
				next_loading   = 1'b0;
				next_ev[EV_WIN] = 1'b1;
			end else begin
				next_win_cnt = long_t'(win_cnt - 1'b1);
			end
		end
		if (op == OP_POLL && state != S_IDLE && poll_cnt != '0) begin
			next_poll_cnt = long_t'(poll_cnt - 1'b1);
		end
		case (state)
			S_IDLE: begin
				if (start) begin
					next_op        = start_op;
					next_have_prev = 1'b0;
					next_poll_cnt  = long_t'(TWC_CYCLES);
					if (start_op == OP_READ || start_op == OP_POLL) begin
						next_pins      = PINS_IDLE;
						next_pins.addr = reg_addr;
						next_pins.ce_n = 1'b0;
						next_pins.oe_n = 1'b0;
						next_cnt       = short_t'(ACC_CYC - 4'h1);
						next_state     = S_RLOW;
					end else if (start_op == OP_LOAD && loading
						&& reg_addr[ADDR_W-1:8] != sector) begin
						next_ev[EV_ERR] = 1'b1;
					end else begin
						next_pins       = PINS_IDLE;
						next_pins.ce_n  = 1'b0;
						next_pins.dq_o  = reg_wdata;
						next_pins.dq_oe = 1'b1;
						next_state      = S_SETUP;
						if (start_op == OP_CMD) begin
							next_pins.addr = {3'h0, reg_addr[14:0]};
						end else begin
							next_pins.addr = reg_addr;
							next_loading   = 1'b1;
							next_win_cnt   = long_t'(BLC_CYCLES);
							if (!loading || win_cnt == '0) begin
								next_sector     = reg_addr[ADDR_W-1:8];
								next_load_count = 9'h000;
							end
						end
					end
				end
			end
			S_SETUP: begin
				next_pins.we_n = 1'b0;
				next_cnt       = short_t'(WP_CYC - 4'h1);
				next_state     = S_WLOW;
			end
			S_WLOW: begin
				if (cnt == 4'h0) begin
					next_pins.we_n = 1'b1;
					next_cnt       = short_t'(WPH_CYC - 4'h1);
					next_state     = S_WHIGH;
				end
			end
			S_WHIGH: begin
				if (cnt == 4'h0) begin
					next_pins.ce_n   = 1'b1;
					next_pins.dq_oe  = 1'b0;
					next_ev[EV_DONE] = 1'b1;
					next_state       = S_IDLE;
					if (op == OP_LOAD) begin
						next_load_count = 9'(load_count + 9'h001);
					end
				end
			end
			S_RLOW: begin
				if (cnt == 4'h0) begin
					next_rdata     = DQ_I;
					next_pins.oe_n = 1'b1;
					next_pins.ce_n = 1'b1;
					next_cnt       = short_t'(OEHP_CYC - 4'h1);
					next_state     = S_RHIGH;
				end
			end
			S_RHIGH: begin
				if (cnt == 4'h0) begin
					if (op != OP_POLL) begin
						next_ev[EV_DONE] = 1'b1;
						next_state       = S_IDLE;
					end else if (have_prev && rdata[6] == prev_t6) begin
						next_ev[EV_DONE] = 1'b1;
						next_ev[EV_PROG] = 1'b1;
						next_state       = S_IDLE;
					end else if (poll_cnt == '0) begin
						next_ev[EV_ERR] = 1'b1;
						next_state      = S_IDLE;
					end else begin
						next_prev_t6   = rdata[6];
						next_have_prev = 1'b1;
						next_pins.ce_n = 1'b0;
						next_pins.oe_n = 1'b0;
						next_cnt       = short_t'(ACC_CYC - 4'h1);
						next_state     = S_RLOW;
					end
				end
			end
			default: begin
				next_pins  = PINS_IDLE;
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state      <= S_IDLE;
			op         <= OP_READ;
			cnt        <= 4'h0;
			pins       <= PINS_IDLE;
			rdata      <= 8'h00;
			have_prev  <= 1'b0;
			prev_t6    <= 1'b0;
			loading    <= 1'b0;
			win_cnt    <= '0;
			poll_cnt   <= '0;
			sector     <= '0;
			load_count <= 9'h000;
			ev         <= 4'h0;
		end else begin
			state      <= next_state;
			op         <= next_op;
			cnt        <= next_cnt;
			pins       <= next_pins;
			rdata      <= next_rdata;
			have_prev  <= next_have_prev;
			prev_t6    <= next_prev_t6;
			loading    <= next_loading;
			win_cnt    <= next_win_cnt;
			poll_cnt   <= next_poll_cnt;
			sector     <= next_sector;
			load_count <= next_load_count;
			ev         <= next_ev;
		end
	end

	assign S_AXI_AWREADY = awready;
	assign S_AXI_WREADY  = wready;
	assign S_AXI_ARREADY = arready;
	assign S_AXI_BVALID  = bvalid;
	assign S_AXI_BRESP   = bresp;
	assign S_AXI_RVALID  = rvalid;
	assign S_AXI_RDATA   = rdout;
	assign S_AXI_RRESP   = rresp;
	assign IRQ           = irq;
	assign CE_N          = pins.ce_n;
	assign OE_N          = pins.oe_n;
	assign WE_N          = pins.we_n;
	assign ADDR          = pins.addr;
	assign DQ_O          = pins.dq_o;
	assign DQ_OE         = pins.dq_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	chk_oe_write_high: assert property (!WE_N && !CE_N |-> OE_N)
		else $error("output enable low during write strobe");
	chk_sector_match: assert property (state == S_SETUP && op == OP_LOAD |-> ADDR[17:8] == sector)
		else $error("sector address differs within a load");
	chk_cmd_low_addr: assert property (state == S_SETUP && op == OP_CMD |-> ADDR[17:15] == 3'h0)
		else $error("command cycle drives upper address bits");
	chk_window_expiry: assert property (loading && win_cnt == '0 |=> ev[EV_WIN] && !(loading && $past(state) != S_IDLE))
		else $error("byte load window expiry not reported");
	chk_load_counted: assert property (state == S_WHIGH && cnt == 4'h0 && op == OP_LOAD |=> load_count == 9'($past(load_count) + 9'h001))
		else $error("sector byte load not counted");
	chk_poll_same_addr: assert property (op == OP_POLL && state == S_RHIGH |=> $stable(ADDR))
		else $error("poll address changed between reads");
	chk_toggle_stable: assert property (state == S_RHIGH && cnt == 4'h0 && op == OP_POLL && have_prev && rdata[6] == prev_t6 |=> ev[EV_PROG] && state == S_IDLE)
		else $error("stable toggle bit not taken as program end");
	chk_poll_timeout: assert property (state == S_RHIGH && cnt == 4'h0 && op == OP_POLL && poll_cnt == '0 && !(have_prev && rdata[6] == prev_t6) |=> ev[EV_ERR])
		else $error("poll timeout not flagged");
	chk_write_pulse: assert property ($fell(WE_N) |-> !WE_N[*4] ##1 WE_N)
		else $error("write pulse width wrong");

	cov_load_done: cover property (state == S_WHIGH && op == OP_LOAD ##1 ev[EV_DONE]);
	cov_prog_done: cover property (ev[EV_PROG]);
	cov_window_end: cover property (ev[EV_WIN]);

endmodule

`default_nettype wire

// >>> bench/flash_model.sv
// bench model of the sector flash as seen at its strobes
// assumes the host clock to time the load window and program cycle and to vary the pattern on released lines
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
	parameter int         BLC_M      = 200,
	parameter int         PROG_M     = 120,
	parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
	parameter logic [7:0] PART_CODE  = 8'h6b, // arbitrary value
	parameter logic [7:0] PROT_ON_CMD  = 8'h11,
	parameter logic [7:0] PROT_OFF_CMD = 8'h22,
	parameter logic [7:0] LOCK_LO_CMD  = 8'h33,
	parameter logic [7:0] LOCK_HI_CMD  = 8'h44,
	parameter int         BOOT_SECTS   = 32
) (
	input  wire logic        clk,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  dq_in,
	output logic [7:0]       dq_out
);
	logic [7:0]  mem [int];
	logic [7:0]  pbuf [int];
	logic        id_mode = 1'b0;
	logic        busy = 1'b0;
	logic        loading = 1'b0;
	logic        tog = 1'b0;
	logic        prot = 1'b0, prot_on = 1'b0, prot_off = 1'b0, lock_lo = 1'b0, lock_hi = 1'b0;
	logic [7:0]  last_d = 8'h00;
	logic [17:0] last_wa = '0;
	logic [17:0] poll_a = '0;
	logic [9:0]  sect = '0;
	int          seq = 0, n_loads = 0, seen = 0, idle = 0, left = 0, n_rd = 0, bad_poll = 0;

	always @(posedge we_n) begin
		if (!ce_n && !busy) begin
			last_wa = addr;
			if (seq == 0 && addr[14:0] == 15'h5555 && dq_in == 8'haa)
				seq = 1;
			else if (seq == 1 && addr[14:0] == 15'h2aaa && dq_in == 8'h55)
				seq = 2;
			else if (seq == 2 && addr[14:0] == 15'h5555) begin
				if (dq_in == 8'h90) id_mode = 1'b1;
				if (dq_in == 8'hf0) id_mode = 1'b0;
				if (dq_in == PROT_ON_CMD) prot_on = 1'b1;
				if (dq_in == PROT_OFF_CMD) prot_off = 1'b1;
				if (dq_in == LOCK_LO_CMD) lock_lo = 1'b1;
				if (dq_in == LOCK_HI_CMD) lock_hi = 1'b1;
				seq = 0;
			end else begin
				seq = 0;
				if (!prot || prot_on || prot_off) begin
					pbuf[addr] = dq_in;
					sect = addr[17:8];
					last_d = dq_in;
					loading = 1'b1;
					n_loads++;
				end
			end
		end
	end

	// timer runs on the falling edge so read data never moves at a sampling edge
	always @(negedge clk) begin
		if (busy) begin
			left--;
			if (left == 0) begin
				if (!(lock_lo && int'(sect) < BOOT_SECTS)
					&& !(lock_hi && int'(sect) >= 1024 - BOOT_SECTS)) begin
					for (int i = 0; i < 256; i++)
						mem[{sect, 8'(i)}] = 8'hxx;
					foreach (pbuf[a]) mem[a] = pbuf[a];
				end
				if (prot_on && pbuf.size() == 256) prot = 1'b1;
				if (prot_off) prot = 1'b0;
				prot_on = 1'b0;
				prot_off = 1'b0;
				pbuf.delete();
				busy = 1'b0;
			end
		end else if (loading) begin
			idle = (n_loads != seen) ? 0 : idle + 1;
			seen = n_loads;
			if (idle >= BLC_M) begin
				loading = 1'b0;
				busy = 1'b1;
				left = PROG_M;
			end
		end
	end

	always @(negedge oe_n) begin
		#1;
		if (!ce_n && busy) begin
			tog = ~tog;
			if (n_rd > 0 && addr != poll_a) bad_poll++;
			n_rd++;
			poll_a = addr;
		end
	end

	function automatic logic [7:0] rdval(input logic [17:0] a);
		if (busy) return {~last_d[7], tog, 6'h00};
		if (id_mode && a[17:1] == '0) return a[0] ? PART_CODE : MAKER_CODE;
		if (id_mode && a == 18'h00002) return {7'h7f, lock_lo};
		if (id_mode && a == 18'h3fff2) return {7'h7f, lock_hi};
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction

	// released lines show a pattern that changes at every clock edge, twice per cycle
	always @(clk or ce_n or oe_n or addr)
		dq_out = (!ce_n && !oe_n) ? rdval(addr) : 8'h55 ^ {8{clk}};
endmodule
`default_nettype wire

// >>> bench/flash_host_tb.sv
// testbench of the flash host controller with a bench flash model
// assumes shortened load window and poll timeout parameters
`timescale 1ns/1ps
`default_nettype none
module flash_host_tb import flash_host_pkg::*;;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, v;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [1:0]  bresp, rresp, rs;
	logic        awready, wready, bvalid, arready, rvalid, irq, ce_n, oe_n, we_n, dq_oe;
	logic [17:0] addr;
	logic [7:0]  dq_o, dq_i;
	int          n_mismatch = 0, n_tests = 0;

	always #12.5 clk = ~clk;

	flash_host #(.BLC_CYCLES(200), .TWC_CYCLES(300)) dut_u (.CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq), .CE_N(ce_n),
		.OE_N(oe_n), .WE_N(we_n), .ADDR(addr), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i));
	flash_model #(.BLC_M(200), .PROG_M(120)) mdl_u (.clk(clk), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .dq_in(dq_o), .dq_out(dq_i));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	always @(negedge clk)
		if (rst_n && !ce_n && !we_n) check({oe_n, dq_oe}, 2'b11);
	always @(negedge clk)
		if (rst_n && !oe_n) check(dq_oe, 1'b0);

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ah) arvalid <= 1'b0;
		end while (!rh);
		rready <= 1'b0;
	endtask

	task automatic wait_reg(input logic [7:0] a, input int i, input logic b);
		int k;
		k = 0;
		do begin
			axr(a, v, rs);
			k++;
		end while (v[i] !== b && k < 400);
		if (v[i] !== b) n_mismatch++;
	endtask

	task automatic settle(input logic [17:0] a);
		wait_reg(OFS_ISTAT, EV_WIN, 1'b1);
		axw(OFS_ISTAT, 32'hf, rs);
		flop(OP_POLL, a, 8'h00);
	endtask

	task automatic flop(input op_t op, input logic [17:0] a, input logic [7:0] d);
		axw(OFS_ADDR, {14'h0, a}, rs);
		axw(OFS_WDATA, {24'h0, d}, rs);
		axw(OFS_CMD, {30'h0, op}, rs);
		wait_reg(OFS_STATUS, ST_BUSY, 1'b0);
	endtask

	task automatic rdv(input logic [17:0] a);
		flop(OP_READ, a, 8'h00);
		axr(OFS_RDATA, v, rs);
	endtask

	task automatic cmd3(input logic [7:0] c);
		flop(OP_CMD, 18'h3d555, 8'haa);
		flop(OP_CMD, 18'h3aaaa, 8'h55);
		flop(OP_CMD, 18'h35555, c);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		for (int i = 0; i < 7; i++) begin
			axr(8'(i * 4), v, rs);
			check(v, 32'h0);
		end
		axr(8'h1c, v, rs);
		check(rs, RESP_SLVERR);
		axw(8'h20, 32'h1, rs);
		check(rs, RESP_SLVERR);
		axw(OFS_IMASK, 32'hf, rs);
		axr(OFS_IMASK, v, rs);
		check(v, 32'hf);
		check(irq, 1'b0);
		$display("register test done");
	endtask

	task automatic t_load;
		flop(OP_LOAD, 18'h00100, 8'ha5);
		flop(OP_LOAD, 18'h00101, 8'h5a);
		axr(OFS_STATUS, v, rs);
		check(v[12:4], 9'd2);
		check(v[ST_LOADING], 1'b1);
		flop(OP_LOAD, 18'h00200, 8'h77);
		axr(OFS_ISTAT, v, rs);
		check(v[EV_ERR], 1'b1);
		check(mdl_u.n_loads, 2);
		wait_reg(OFS_ISTAT, EV_WIN, 1'b1);
		check(v[EV_WIN], 1'b1);
		rdv(18'h00101);
		check(v[7], 1'b1);
		flop(OP_POLL, 18'h00101, 8'h00);
		axr(OFS_ISTAT, v, rs);
		check(v[EV_PROG], 1'b1);
		check(mdl_u.bad_poll, 0);
		check(mdl_u.busy, 1'b0);
		rdv(18'h00101);
		check(v, 32'h5a);
		rdv(18'h00100);
		check(v, 32'ha5);
		check(irq, 1'b1);
		axw(OFS_IMASK, 32'h0, rs);
		@(negedge clk);
		check(irq, 1'b0);
		axw(OFS_IMASK, 32'h8, rs);
		@(negedge clk);
		check(irq, 1'b1);
		axw(OFS_ISTAT, 32'h8, rs);
		@(negedge clk);
		check(irq, 1'b0);
		$display("load and poll test done");
	endtask

	task automatic t_id;
		cmd3(8'h90);
		check(mdl_u.last_wa, 18'h05555);
		rdv(18'h00000);
		check(v, {24'h0, mdl_u.MAKER_CODE});
		rdv(18'h00001);
		check(v, {24'h0, mdl_u.PART_CODE});
		rdv(18'h00002);
		check(v, 32'hfe);
		cmd3(8'hf0);
		rdv(18'h00101);
		check(v, 32'h5a);
		$display("identification test done");
	endtask

	task automatic t_prot;
		cmd3(mdl_u.PROT_ON_CMD);
		for (int i = 0; i < 256; i++)
			flop(OP_LOAD, {10'h002, 8'(i)}, 8'(i));
		axr(OFS_STATUS, v, rs);
		check(v[12:4], 9'h100);
		settle(18'h00203);
		check(mdl_u.prot, 1'b1);
		rdv(18'h00203);
		check(v, 32'h03);
		flop(OP_LOAD, 18'h00300, 8'h66);
		settle(18'h00300);
		rdv(18'h00300);
		check(v, 32'hff);
		cmd3(mdl_u.PROT_OFF_CMD);
		flop(OP_LOAD, 18'h00300, 8'h66);
		settle(18'h00300);
		check(mdl_u.prot, 1'b0);
		rdv(18'h00300);
		check(v, 32'h66);
		$display("protection test done");
	endtask

	task automatic t_lock;
		cmd3(mdl_u.LOCK_LO_CMD);
		flop(OP_LOAD, 18'h00010, 8'h12);
		settle(18'h00010);
		rdv(18'h00010);
		check(v, 32'hff);
		cmd3(mdl_u.LOCK_HI_CMD);
		flop(OP_LOAD, 18'h3ff10, 8'h34);
		settle(18'h3ff10);
		rdv(18'h3ff10);
		check(v, 32'hff);
		cmd3(8'h90);
		rdv(18'h00002);
		check(v, 32'hff);
		rdv(18'h3fff2);
		check(v, 32'hff);
		cmd3(8'hf0);
		$display("lockout test done");
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs;
		t_load;
		t_id;
		t_prot;
		t_lock;
		test_done;
	end

	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		test_done;
	end
endmodule
`default_nettype wire
